/* serial_pkg.sv */
package serial_pkg;
    // Port addresses of the serial block on the CPU I/O space.
    localparam logic [3:0] PORT_CTRL   = 4'hd;
    localparam logic [3:0] PORT_BUF_LO = 4'he;
    localparam logic [3:0] PORT_BUF_HI = 4'hf;
    // Control register field positions.
    localparam int CTL_IEN      = 0;
    localparam int CTL_START    = 1;
    localparam int CTL_SYNC     = 2;
    localparam int CTL_XMIT     = 3;
    localparam int CTL_CLK_INT  = 4;
    localparam int CTL_WLEN_LSB = 5;
    localparam logic [7:0] CTL_RESET = 8'h00;
    // Status register field positions.
    localparam int STS_READY = 0;
    localparam int STS_ERROR = 1;
    // Baud generator and shift clock timing.
    localparam int CLK_MHZ       = 100;
    localparam int BAUD_HALF_NS  = 1000;
    localparam int BAUD_HALF_CYC = BAUD_HALF_NS * CLK_MHZ / 1000;
    localparam logic [15:0] BAUD_HALF_LAST = 16'(BAUD_HALF_CYC - 1);
    localparam logic [3:0] DIV_RISE = 4'h7;
    localparam logic [3:0] DIV_FALL = 4'hf;
    localparam logic [2:0] CONFIRM_LAST = 3'h6;
    // Word length per select code, code 0 in the low five bits.
    localparam logic [39:0] WORD_LEN_DEFAULT = {5'd13, 5'd12, 5'd11, 5'd10,
                                                5'd9, 5'd8, 5'd7, 5'd16};
    localparam int FIFO_DEPTH = 8;
    localparam int WORD_W     = 16;
endpackage : serial_pkg

/* word_if.sv */
interface word_if;
    logic        valid;
    logic        ready;
    logic [15:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface : word_if

/* word_fifo.sv */
module word_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic sys_clk_i,
    input  wire logic srst_i,
    word_if.dst       push,
    word_if.src       pop
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [WIDTH-1:0] head;
    wire              do_wr   = push.valid && push.ready;
    wire              do_rd   = pop.valid && pop.ready;
    wire [AW-1:0]     next_rd = do_rd ? AW'(rd_ptr + 1'b1) : rd_ptr;

    // Full and empty come straight from the occupancy count.
    assign push.ready = (count != (AW+1)'(DEPTH));
    assign pop.valid  = (count != '0);
    assign pop.data   = head;

    // Head word is registered; a write into the slot about to be read is bypassed.
    always_ff @(posedge sys_clk_i) begin
        if (do_wr) begin
            mem[wr_ptr] <= push.data;
        end
        head <= (do_wr && wr_ptr == next_rd) ? push.data : mem[next_rd];
    end

    // Pointers and count.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= do_wr ? AW'(wr_ptr + 1'b1) : wr_ptr;
            rd_ptr <= next_rd;
            count  <= (AW+1)'(count + do_wr - do_rd);
        end
    end
endmodule : word_fifo

/* serial_shift_port.sv */
// What this block does
// - Shift clock equals bit clock in sync mode, bit clock over 16 in async.
// - Serial input sampled on shift clock rise into the top shift bit.
// - Serial output changes only on shift clock fall.
// - Sixteen-bit shift register, double buffered through two byte ports.
// - Bit counter advances on the shift clock for each bit of the word.
// - Bit clock pin is driven by the baud generator or taken as input.
// - Control register is write only; its port reads status instead.
// - Three-bit word length select picks one of eight bit counts.
// - Transmit shifts out the low bit while sampling input into the top.
// - Receive shifts in until the queue is full and holds serial output at one.
// - End of word flagged when the programmed bit count has shifted.
// - Interrupt on end of word only while interrupt enable is set.
// - Half duplex in async and sync alike, transmit or receive per control bit 3, variable length.
// - Control bit 2 low is async, high sync; sync ignores start detect.
// - Start detect waits seven low bit clock samples, resumes shifting after the eighth.
// - Ready set on buffer empty or full, cleared by buffer write or read.
// - Error set on transmit underflow at end of word, cleared by status read.
module serial_shift_port #(
    parameter logic [39:0] WORD_LEN_TABLE = serial_pkg::WORD_LEN_DEFAULT
) (
    input  wire logic       sys_clk_i,
    input  wire logic       srst_i,
    input  wire logic [3:0] io_addr_i,
    input  wire logic       io_wr_i,
    input  wire logic       io_rd_i,
    input  wire logic [7:0] io_wdata_i,
    output logic      [7:0] io_rdata_o,
    input  wire logic       si_i,
    output logic            so_o,
    input  wire logic       serial_bit_clock_pin_i,
    output logic            serial_bit_clock_pin_o,
    output logic            serial_bit_clock_pin_oe_o,
    output logic            irq_o,
    output logic            eow_o
);
    typedef enum logic [2:0] {
        ST_RUN     = 3'b001,
        ST_SEEK    = 3'b010,
        ST_CONFIRM = 3'b100
    } hunt_t;

    logic [7:0]  control;
    logic [15:0] shift_reg;
    logic [15:0] tx_buf;
    logic [15:0] rx_buf;
    logic        tx_pending;
    logic        ready;
    logic        error;
    logic [4:0]  bit_cnt;
    logic [3:0]  div_cnt;
    logic [2:0]  confirm_cnt;
    logic [3:0]  low_seen;
    logic [15:0] baud_cnt;
    logic        serial_bit_clock_pin_prev;
    hunt_t       state;
    hunt_t       next_state;

    word_if rx_push ();
    word_if rx_pop ();

    // Received words queue here so a slow CPU loses nothing until the queue is full.
    word_fifo #(
        .WIDTH (serial_pkg::WORD_W),
        .DEPTH (serial_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .sys_clk_i (sys_clk_i),
        .srst_i    (srst_i),
        .push      (rx_push),
        .pop       (rx_pop)
    );

    // Control field decode.
    wire       ien         = control[serial_pkg::CTL_IEN];
    wire       start_en    = control[serial_pkg::CTL_START];
    wire       sync_mode   = control[serial_pkg::CTL_SYNC];
    wire       transmit_receive_select = control[serial_pkg::CTL_XMIT];
    wire       clk_int     = control[serial_pkg::CTL_CLK_INT];
    wire [2:0] word_length_select = control[serial_pkg::CTL_WLEN_LSB +: 3];
    wire       hunt_on     = start_en && !sync_mode;

    // Length lookup from the parameter table.
    wire [4:0] word_len = WORD_LEN_TABLE[word_length_select*5 +: 5];

    // Port decode.
    wire sel_ctl = (io_addr_i == serial_pkg::PORT_CTRL);
    wire sel_lo  = (io_addr_i == serial_pkg::PORT_BUF_LO);
    wire sel_hi  = (io_addr_i == serial_pkg::PORT_BUF_HI);
    wire wr_ctl  = io_wr_i && sel_ctl;
    wire wr_buf  = io_wr_i && (sel_lo || sel_hi);
    wire rd_sts  = io_rd_i && sel_ctl;
    wire rd_buf  = io_rd_i && (sel_lo || sel_hi);
    wire arm_on  = wr_ctl && io_wdata_i[serial_pkg::CTL_START] &&
                   !io_wdata_i[serial_pkg::CTL_SYNC];

    // Bit clock source: own generator driving the pin, or the pin as input.
    assign serial_bit_clock_pin_oe_o = clk_int;
    wire serial_bit_clock_pin = clk_int ? serial_bit_clock_pin_o : serial_bit_clock_pin_i;
    wire serial_bit_clock_pin_rise = serial_bit_clock_pin && !serial_bit_clock_pin_prev;
    wire serial_bit_clock_pin_fall = !serial_bit_clock_pin && serial_bit_clock_pin_prev;

    // The receive path stalls the shifter when its queue is full.
    wire stall   = !transmit_receive_select && !rx_push.ready;
    wire running = (state == ST_RUN) && !stall;

    // Shift clock edges: bit clock rate in sync, one sixteenth in async.
    wire async_rise = serial_bit_clock_pin_rise && (div_cnt == serial_pkg::DIV_RISE);
    wire async_fall = serial_bit_clock_pin_rise && (div_cnt == serial_pkg::DIV_FALL);
    wire shift_rise = running && (sync_mode ? serial_bit_clock_pin_rise : async_rise);
    wire shift_fall = running && (sync_mode ? serial_bit_clock_pin_fall : async_fall);

    // End of word when the last programmed bit has shifted in.
    wire last_bit = (bit_cnt == 5'(word_len - 5'd1));
    wire eow      = shift_rise && last_bit;

    // Receive words leave the shifter as they stood at end of word.
    assign rx_push.valid = eow && !transmit_receive_select;
    assign rx_push.data  = {si_i, shift_reg[15:1]};
    assign rx_pop.ready  = !transmit_receive_select && !ready;
    wire   rx_take       = rx_pop.valid && rx_pop.ready;

    // Control register is write only; reset leaves the port in receive.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            control <= serial_pkg::CTL_RESET;
        end else if (wr_ctl) begin
            control <= io_wdata_i;
        end
    end

    // Baud generator toggles the driven pin at a fixed half period.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            baud_cnt               <= '0;
            serial_bit_clock_pin_o <= 1'b0;
        end else if (baud_cnt == serial_pkg::BAUD_HALF_LAST) begin
            baud_cnt               <= '0;
            serial_bit_clock_pin_o <= !serial_bit_clock_pin_o;
        end else begin
            baud_cnt <= 16'(baud_cnt + 16'd1);
        end
    end

    // Edge detect on the selected bit clock.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            serial_bit_clock_pin_prev <= 1'b0;
        end else begin
            serial_bit_clock_pin_prev <= serial_bit_clock_pin;
        end
    end

    // Divide-by-16 counter; restarted whenever a start bit is confirmed.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state != ST_RUN) begin
            div_cnt <= '0;
        end else if (serial_bit_clock_pin_rise && !stall) begin
            div_cnt <= 4'(div_cnt + 4'd1);
        end
    end

    // Start detect search. Sync mode never leaves the run state.
    always_comb begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (hunt_on && eow) begin
                    next_state = ST_SEEK;
                end
            end
            ST_SEEK: begin
                if (!hunt_on) begin
                    next_state = ST_RUN;
                end else if (serial_bit_clock_pin_rise && !si_i) begin
                    next_state = ST_CONFIRM;
                end
            end
            ST_CONFIRM: begin
                if (!hunt_on) begin
                    next_state = ST_RUN;
                end else if (serial_bit_clock_pin_rise && si_i) begin
                    next_state = ST_SEEK;
                end else if (serial_bit_clock_pin_rise && confirm_cnt == serial_pkg::CONFIRM_LAST) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // The confirm counter counts low samples after the first one.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            state       <= ST_RUN;
            confirm_cnt <= '0;
        end else begin
            state <= arm_on ? ST_SEEK : next_state;
            if (state != ST_CONFIRM) begin
                confirm_cnt <= '0;
            end else if (serial_bit_clock_pin_rise) begin
                confirm_cnt <= 3'(confirm_cnt + 3'd1);
            end
        end
    end

    // Bit counter runs on the shift clock and wraps at the word end.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i || state != ST_RUN) begin
            bit_cnt <= '0;
        end else if (shift_rise) begin
            bit_cnt <= last_bit ? 5'd0 : 5'(bit_cnt + 5'd1);
        end
    end

    // Shifter: input enters the top bit; a transmit word end loads a pending word instead.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            shift_reg <= '0;
        end else if (eow && transmit_receive_select && tx_pending) begin
            shift_reg <= tx_buf;
        end else if (shift_rise) begin
            shift_reg <= {si_i, shift_reg[15:1]};
        end
    end

    // Output bit moves only on the falling shift edge; receive marks.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            so_o <= 1'b1;
        end else if (shift_fall) begin
            so_o <= transmit_receive_select ? shift_reg[0] : 1'b1;
        end
    end

    // Transmit buffer halves load from the two byte ports.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tx_buf <= '0;
        end else if (io_wr_i && sel_lo) begin
            tx_buf[7:0] <= io_wdata_i;
        end else if (io_wr_i && sel_hi) begin
            tx_buf[15:8] <= io_wdata_i;
        end
    end

    // A buffer write marks data pending; the word end consumes it.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            tx_pending <= 1'b0;
        end else if (wr_buf) begin
            tx_pending <= 1'b1;
        end else if (eow && transmit_receive_select) begin
            tx_pending <= 1'b0;
        end
    end

    // Receive buffer refills from the queue once software has read it.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            rx_buf <= '0;
        end else if (rx_take) begin
            rx_buf <= rx_pop.data;
        end
    end

    // Ready: the set event wins over a clearing access in the same cycle.
    wire ready_set = transmit_receive_select ? (eow && tx_pending) : rx_take;
    wire ready_clr = transmit_receive_select ? wr_buf : rd_buf;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            ready <= 1'b0;
        end else if (ready_set) begin
            ready <= 1'b1;
        end else if (ready_clr) begin
            ready <= 1'b0;
        end
    end

    // Underflow error: set wins over the clearing status read.
    wire underflow = eow && transmit_receive_select && !tx_pending;
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            error <= 1'b0;
        end else if (underflow) begin
            error <= 1'b1;
        end else if (rd_sts) begin
            error <= 1'b0;
        end
    end

    // Read data: status on the control port, receive halves on the two buffer ports, zero elsewhere.
    wire [7:0] status = 8'({error, ready});
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            io_rdata_o <= '0;
        end else if (io_rd_i) begin
            io_rdata_o <= sel_ctl ? status :
                          sel_lo  ? rx_buf[7:0] :
                          sel_hi  ? rx_buf[15:8] : 8'h00;
        end
    end

    // End of word and the gated interrupt leave as one-cycle pulses.
    always_ff @(posedge sys_clk_i) begin
        if (srst_i) begin
            eow_o <= 1'b0;
            irq_o <= 1'b0;
        end else begin
            eow_o <= eow;
            irq_o <= eow && ien;
        end
    end

    // Consecutive low samples during the search, counted apart from the search logic it checks.
    always_ff @(posedge sys_clk_i) begin
        low_seen <= (srst_i || wr_ctl || state == ST_RUN) ? 4'h0 :
                    serial_bit_clock_pin_rise ? (si_i ? 4'h0 : 4'(low_seen + 4'h1)) : low_seen;
    end

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (srst_i);

    sequence s_eighth_low;
        hunt_on && !wr_ctl && state != ST_RUN && serial_bit_clock_pin_rise && !si_i && low_seen == 4'h7;
    endsequence

    chk_async_rate: assert property (
        shift_rise && !sync_mode |-> div_cnt == serial_pkg::DIV_RISE && serial_bit_clock_pin_rise)
        else $error("async shift rise off the divided clock");
    chk_sync_rate: assert property (
        running && sync_mode && serial_bit_clock_pin_rise |-> shift_rise)
        else $error("sync bit clock rise missed");
    chk_top_sample: assert property (
        shift_rise && !(eow && transmit_receive_select && tx_pending)
        |=> shift_reg[15] == $past(si_i) && shift_reg[14:0] == $past(shift_reg[15:1]))
        else $error("input not shifted into top bit");
    chk_so_edge: assert property (
        !$stable(so_o) |-> $past(shift_fall))
        else $error("serial output moved off a falling edge");
    chk_bit_count: assert property (
        shift_rise && !last_bit |=> bit_cnt == $past(bit_cnt) + 5'd1)
        else $error("bit counter did not advance");
    chk_recv_mark: assert property (
        !transmit_receive_select && $past(!transmit_receive_select) && $past(shift_fall)
        |-> so_o)
        else $error("receive mode output not marking");
    chk_word_end: assert property (
        eow |-> bit_cnt == 5'(word_len - 5'd1) ##1 eow_o && bit_cnt == 5'd0)
        else $error("end of word at wrong count");
    chk_irq_gate: assert property (
        irq_o |-> $past(eow) && $past(ien))
        else $error("interrupt without enabled end of word");
    chk_start_hold: assert property (
        state != ST_RUN |=> $stable(shift_reg) && $stable(so_o))
        else $error("shifter moved during start search");
    chk_start_go: assert property (
        s_eighth_low |=> state == ST_RUN)
        else $error("start bit not accepted on eighth sample");
    chk_tx_ready: assert property (
        transmit_receive_select && wr_buf && !ready_set && !wr_ctl |=> !ready)
        else $error("buffer write did not clear ready");
    chk_underflow: assert property (
        underflow |=> error)
        else $error("underflow did not set error");
endmodule : serial_shift_port

/* serial_partner.sv */
// Far-side serial logic: it makes the bit clock, drives serial data and captures serial output.
module serial_partner (
    input  wire logic sys_clk_i,
    input  wire logic so_i,
    output logic      bit_clk_o,
    output logic      si_o
);
    timeunit 1ns;
    timeprecision 100ps;

    int          rises;
    logic [15:0] cap;
    logic        so_low;

    // The clock is parked low between frames and the data line idles at marking level.
    initial begin
        bit_clk_o = 1'b0;
        si_o      = 1'b1;
        rises     = 0;
        cap       = 16'h0000;
        so_low    = 1'b0;
    end

    task automatic clear();
        cap    = 16'h0000;
        so_low = 1'b0;
    endtask : clear

    // Data moves while the clock is low, three cycles before the rise, so it is settled when
    // sampled; serial output is taken at the rise, after the device moved it on the fall.
    task automatic pulses(input logic [15:0] v, input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk_i);
            #1;
            si_o = v[i % 16];
            repeat (3) @(posedge sys_clk_i);
            #1;
            bit_clk_o = 1'b1;
            rises++;
            cap = {so_i, cap[15:1]};
            if (so_i !== 1'b1) so_low = 1'b1;
            repeat (3) @(posedge sys_clk_i);
            #1;
            bit_clk_o = 1'b0;
        end
    endtask : pulses
endmodule : serial_partner

/* testbench.sv */
`define CHK(what, exp, got) \
    begin \
        check_count++; \
        if ((got) !== (exp)) begin \
            n_mismatch++; \
            $display("[FAIL] %s expected %0h seen %0h", what, exp, got); \
        end \
    end

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    localparam int LIMIT = 60000;

    logic        sys_clk_i;
    logic        srst_i;
    logic [3:0]  io_addr;
    logic        io_wr;
    logic        io_rd;
    logic [7:0]  io_wdata;
    logic [7:0]  io_rdata;
    logic        si;
    logic        so;
    logic        pin_o;
    logic        pin_oe;
    logic        part_clk;
    logic        pin_level;
    logic        irq;
    logic        eow;
    logic [7:0]  rd;
    logic [7:0]  lo;
    logic [15:0] mask;
    logic        prev;
    int          n_mismatch;
    int          check_count;
    int          cycles;
    int          eow_cnt;
    int          irq_cnt;
    int          eow_last;
    int          eow_prev;
    int          base_e;
    int          base_i;
    int          base_r;
    int          len;
    int          tog;

    // The pin carries the device's drive while enabled, otherwise the partner's clock.
    assign pin_level = pin_oe ? pin_o : part_clk;

    serial_shift_port uut (
        .sys_clk_i                 (sys_clk_i),
        .srst_i                    (srst_i),
        .io_addr_i                 (io_addr),
        .io_wr_i                   (io_wr),
        .io_rd_i                   (io_rd),
        .io_wdata_i                (io_wdata),
        .io_rdata_o                (io_rdata),
        .si_i                      (si),
        .so_o                      (so),
        .serial_bit_clock_pin_i    (pin_level),
        .serial_bit_clock_pin_o    (pin_o),
        .serial_bit_clock_pin_oe_o (pin_oe),
        .irq_o                     (irq),
        .eow_o                     (eow)
    );

    serial_partner sp (
        .sys_clk_i (sys_clk_i),
        .so_i      (so),
        .bit_clk_o (part_clk),
        .si_o      (si)
    );

    always #5 sys_clk_i = ~sys_clk_i;

    // Pulses are counted on the falling edge so they never race the launching edge.
    always @(negedge sys_clk_i) begin
        if (eow === 1'b1) begin
            eow_cnt++;
            eow_prev = eow_last;
            eow_last = sp.rises;
        end
        if (irq === 1'b1) irq_cnt++;
    end

    // A hang is cut short here and reported as a mismatch.
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            close_out();
        end
    end

    task automatic close_out();
        $display("Checks made %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : close_out

    task automatic settle(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : settle

    task automatic reset_dut();
        @(posedge sys_clk_i);
        #1;
        srst_i = 1'b1;
        settle(10);
        srst_i = 1'b0;
    endtask : reset_dut

    task automatic io_write(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        io_addr  = a;
        io_wdata = d;
        io_wr    = 1'b1;
        settle(1);
        io_wr = 1'b0;
    endtask : io_write

    // Read data is registered at the strobe's edge and is settled just after it.
    task automatic io_read(input logic [3:0] a, output logic [7:0] d);
        @(posedge sys_clk_i);
        #1;
        io_addr = a;
        io_rd   = 1'b1;
        settle(1);
        io_rd = 1'b0;
        d     = io_rdata;
    endtask : io_read

    initial begin
        sys_clk_i = 1'b0;
        srst_i    = 1'b1;
        io_addr   = 4'h0;
        io_wr     = 1'b0;
        io_rd     = 1'b0;
        io_wdata  = 8'h00;
        reset_dut();
        `CHK("serial out idle", 1'b1, so);
        `CHK("pin drive", 1'b0, pin_oe);
        io_read(serial_pkg::PORT_CTRL, rd);
        `CHK("status after reset", 8'h00, rd);
        io_read(4'h3, rd);
        `CHK("unmapped port", 8'h00, rd);
        // Every length code in sync receive; odd codes also enable the interrupt.
        for (int c = 0; c < 8; c++) begin
            len = int'(serial_pkg::WORD_LEN_DEFAULT[c*5 +: 5]);
            reset_dut();
            sp.clear();
            io_write(serial_pkg::PORT_CTRL, {c[2:0], 4'b0010, c[0]});
            base_e = eow_cnt;
            base_i = irq_cnt;
            base_r = sp.rises;
            sp.pulses(16'hb38d, len);
            settle(4);
            `CHK("words", 1, eow_cnt - base_e);
            `CHK("bits per word", len, eow_last - base_r);
            `CHK("irq count", c % 2, irq_cnt - base_i);
            io_read(serial_pkg::PORT_CTRL, rd);
            `CHK("ready on full", 8'h01, rd);
            io_read(serial_pkg::PORT_BUF_LO, lo);
            io_read(serial_pkg::PORT_BUF_HI, rd);
            mask = 16'hffff << (16 - len);
            `CHK("rx word", (16'hb38d << (16 - len)) & mask, {rd, lo} & mask);
            `CHK("so marking", 1'b0, sp.so_low);
            io_read(serial_pkg::PORT_CTRL, rd);
            `CHK("ready after read", 8'h00, rd);
        end
        // Sync transmit, sixteen bits: the buffer loads at the first end of word.
        reset_dut();
        io_write(serial_pkg::PORT_CTRL, 8'h0c);
        io_write(serial_pkg::PORT_BUF_LO, 8'hc3);
        io_write(serial_pkg::PORT_BUF_HI, 8'ha5);
        io_read(serial_pkg::PORT_CTRL, rd);
        `CHK("ready after load", 8'h00, rd);
        sp.pulses(16'h0000, 16);
        settle(4);
        io_read(serial_pkg::PORT_CTRL, rd);
        `CHK("ready on empty", 8'h01, rd);
        sp.clear();
        sp.pulses(16'h0000, 16);
        settle(4);
        `CHK("tx word", 16'ha5c3, sp.cap);
        io_read(serial_pkg::PORT_CTRL, rd);
        `CHK("underflow", 8'h03, rd);
        io_read(serial_pkg::PORT_CTRL, rd);
        `CHK("error cleared", 8'h01, rd);
        // Seven bits: one start, five data, one stop, received in async at one sixteenth rate.
        len = int'(serial_pkg::WORD_LEN_DEFAULT[9:5]);
        reset_dut();
        io_write(serial_pkg::PORT_CTRL, 8'h20);
        sp.pulses(16'hffff, 240);
        settle(4);
        `CHK("async interval", 16 * len, eow_last - eow_prev);
        // Async transmit: the loaded word's bits leave on every sixteenth bit clock only.
        reset_dut();
        io_write(serial_pkg::PORT_CTRL, 8'h28);
        io_write(serial_pkg::PORT_BUF_LO, 8'h01);
        sp.pulses(16'h0000, 112);
        settle(4);
        `CHK("async first bit", 1'b1, so);
        sp.pulses(16'h0000, 15);
        settle(4);
        `CHK("async bit held", 1'b1, so);
        sp.pulses(16'h0000, 1);
        settle(4);
        `CHK("async second bit", 1'b0, so);
        // Start detect waits through a marking line, then one word after the start bit.
        reset_dut();
        io_write(serial_pkg::PORT_CTRL, 8'h22);
        base_e = eow_cnt;
        sp.pulses(16'hffff, 200);
        settle(4);
        `CHK("no start", 0, eow_cnt - base_e);
        sp.pulses(16'h0000, 8 + 16 * len);
        settle(4);
        `CHK("start found", 1, eow_cnt - base_e);
        reset_dut();
        io_write(serial_pkg::PORT_CTRL, 8'h26);
        base_e = eow_cnt;
        sp.pulses(16'hffff, len);
        settle(4);
        `CHK("sync ignores start", 1, eow_cnt - base_e);
        // The baud generator drives the pin; edges are counted over a whole number of periods.
        reset_dut();
        io_write(serial_pkg::PORT_CTRL, 8'h10);
        settle(2);
        `CHK("pin driven", 1'b1, pin_oe);
        prev = pin_o;
        tog  = 0;
        repeat (1000) begin
            settle(1);
            if (pin_o !== prev) tog++;
            prev = pin_o;
        end
        `CHK("baud edges", 1000 / serial_pkg::BAUD_HALF_CYC, tog);
        io_write(serial_pkg::PORT_CTRL, 8'h00);
        settle(2);
        `CHK("pin released", 1'b0, pin_oe);
        // Receive without reading until the buffer refuses, then drain it in order.
        reset_dut();
        io_write(serial_pkg::PORT_CTRL, 8'h24);
        base_e = eow_cnt;
        for (int w = 0; w < 12; w++) sp.pulses(16'(w), 7);
        settle(4);
        `CHK("words before stall", serial_pkg::FIFO_DEPTH + 1, eow_cnt - base_e);
        for (int w = 0; w <= serial_pkg::FIFO_DEPTH; w++) begin
            settle(4);
            io_read(serial_pkg::PORT_CTRL, rd);
            `CHK("ready while draining", 8'h01, rd);
            io_read(serial_pkg::PORT_BUF_HI, rd);
            `CHK("drained word", 7'(w), rd[7:1]);
        end
        settle(4);
        io_read(serial_pkg::PORT_CTRL, rd);
        `CHK("drained empty", 8'h00, rd);
        close_out();
    end
endmodule : testbench
